// ===== fldet_map.svh
// Register map, codes and reset values of the frequency level detector
`ifndef FLDET_MAP_SVH
`define FLDET_MAP_SVH
// Register indices; byte address is index times four
`define FLD_IDX_OUT1_SEL 12'h0a00
`define FLD_IDX_OUT2_SEL 12'h0a01
`define FLD_IDX_RLYA_SEL 12'h0a02
`define FLD_IDX_RLYB_SEL 12'h0a03
`define FLD_IDX_LV1_THR  12'h0a14
`define FLD_IDX_LV1_HYS  12'h0a15
`define FLD_IDX_LV2_THR  12'h0a16
`define FLD_IDX_LV2_HYS  12'h0a17
`define FLD_IDX_BAND     12'h0a18
`define FLD_IDX_LIVE     12'h0a30
`define FLD_IDX_IRQ_STS  12'h0a31
`define FLD_IDX_IRQ_MSK  12'h0a32
// Reset values
`define FLD_RST_OUT1_SEL 16'h0002
`define FLD_RST_OUT2_SEL 16'h0002
`define FLD_RST_RLYA_SEL 16'h0008
`define FLD_RST_RLYB_SEL 16'h0000
`define FLD_RST_THR      16'h01f4
`define FLD_RST_PCT      16'h0000
// Selector codes and limits
`define FLD_SEL_MAX      16'h0023
`define FLD_SEL_LEVEL1   16'h000f
`define FLD_SEL_LEVEL2   16'h0010
`define FLD_SEL_ARRIVE   16'h0011
`define FLD_PCT_FULL     16'h03e8
`define FLD_PCT_DIV      32'h0000_03e8
// Event bit positions
`define FLD_EV_LEVEL1    0
`define FLD_EV_LEVEL2    1
`define FLD_EV_ARRIVE    2
`endif

// ===== fldet_pkg.sv
// Types shared by the frequency level detector
package fldet_pkg;

    typedef enum logic [1:0] {
        FLD_BUS_IDLE   = 2'b00,
        FLD_BUS_WRITE  = 2'b01,
        FLD_BUS_RDWAIT = 2'b10,
        FLD_BUS_RDDONE = 2'b11
    } fldet_bus_e;

    // Running frequency sample, 0.01 Hz units
    typedef struct packed {
        logic [15:0] freq;
        logic        update;
    } fldet_freq_s;

    // Reference frequencies from the drive, 0.01 Hz units
    typedef struct packed {
        logic [15:0] set_freq;
        logic [15:0] max_freq;
    } fldet_ref_s;

    typedef struct packed {
        logic output_terminal_one;
        logic output_terminal_two;
        logic relay_a_output;
        logic relay_b_output;
    } fldet_term_s;

    typedef struct packed {
        fldet_bus_e       bus;
        logic [11:0]      idx;
        logic             hit;
        logic [31:0]      rdata;
        logic [3:0][15:0] sel;
        logic [15:0]      thr1;
        logic [15:0]      hys1;
        logic [15:0]      thr2;
        logic [15:0]      hys2;
        logic [15:0]      band;
        logic             det1;
        logic             det2;
        logic             arr;
        logic [2:0]       sts;
        logic [2:0]       msk;
        logic             irq;
        fldet_term_s      term;
    } fldet_state_s;

endpackage : fldet_pkg

// ===== fldet.sv
// Frequency level and arrival detectors with AHB-Lite register slave
`timescale 1ns/10ps
`include "fldet_map.svh"

module fldet (
    // Clock and reset
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // AHB-Lite slave
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic [31:0]                 hrdata,
    // Drive frequencies
    input  wire fldet_pkg::fldet_freq_s run_in,
    input  wire fldet_pkg::fldet_ref_s  ref_in,
    // Terminals and interrupt
    output fldet_pkg::fldet_term_s      term_out,
    output logic                        irq
);
    import fldet_pkg::*;

    localparam fldet_state_s ST_RST = '{
        bus:  FLD_BUS_IDLE,
        sel:  {`FLD_RST_RLYB_SEL, `FLD_RST_RLYA_SEL,
               `FLD_RST_OUT2_SEL, `FLD_RST_OUT1_SEL},
        thr1: `FLD_RST_THR,
        hys1: `FLD_RST_PCT,
        thr2: `FLD_RST_THR,
        hys2: `FLD_RST_PCT,
        band: `FLD_RST_PCT,
        default: '0
    };

    fldet_state_s s_q;
    fldet_state_s s_d;

    logic [15:0] lag1;
    logic [15:0] lag2;
    logic [15:0] half_band;
    logic [16:0] band_lo;
    logic [16:0] band_hi;
    logic [2:0]  events;
    logic [15:0] wval;

    // Value times a 0.1 % percentage; result never exceeds value
    function automatic logic [15:0] pct_of(
        input logic [15:0] value,
        input logic [15:0] pct
    );
        logic [31:0] prod;
        prod = 32'(value) * 32'(pct);
        return 16'(prod / `FLD_PCT_DIV);
    endfunction

    // Routes one detector result to a terminal by its selector
    function automatic logic route(
        input logic [15:0] code,
        input logic        lv1,
        input logic        lv2,
        input logic        arrive
    );
        logic r;
        r = 1'b0;
        case (code)
            `FLD_SEL_LEVEL1: begin
                r = lv1;
            end
            `FLD_SEL_LEVEL2: begin
                r = lv2;
            end
            `FLD_SEL_ARRIVE: begin
                r = arrive;
            end
            default: begin
                r = 1'b0;
            end
        endcase
        return r;
    endfunction

    // Release points and arrival window
    assign lag1      = pct_of(s_q.thr1, s_q.hys1);
    assign lag2      = pct_of(s_q.thr2, s_q.hys2);
    assign half_band = pct_of(ref_in.max_freq, s_q.band);
    // Extra bit keeps set plus band from wrapping; low edge clamps at zero
    assign band_hi   = {1'b0, ref_in.set_freq} + {1'b0, half_band};
    assign band_lo   = {1'b0, run_in.freq} + {1'b0, half_band};
    assign wval      = hwdata[15:0];

    always_comb begin
        s_d = s_q;

        // Data phase of the previous bus transfer
        case (s_q.bus)
            FLD_BUS_WRITE: begin
                if (s_q.hit) begin
                    case (s_q.idx)
                        `FLD_IDX_OUT1_SEL: begin
                            if (wval <= `FLD_SEL_MAX) begin
                                s_d.sel[0] = wval;
                            end
                        end
                        `FLD_IDX_OUT2_SEL: begin
                            if (wval <= `FLD_SEL_MAX) begin
                                s_d.sel[1] = wval;
                            end
                        end
                        `FLD_IDX_RLYA_SEL: begin
                            if (wval <= `FLD_SEL_MAX) begin
                                s_d.sel[2] = wval;
                            end
                        end
                        `FLD_IDX_RLYB_SEL: begin
                            if (wval <= `FLD_SEL_MAX) begin
                                s_d.sel[3] = wval;
                            end
                        end
                        `FLD_IDX_LV1_THR: begin
                            if (wval <= ref_in.max_freq) begin
                                s_d.thr1 = wval;
                            end
                        end
                        `FLD_IDX_LV1_HYS: begin
                            if (wval <= `FLD_PCT_FULL) begin
                                s_d.hys1 = wval;
                            end
                        end
                        `FLD_IDX_LV2_THR: begin
                            if (wval <= ref_in.max_freq) begin
                                s_d.thr2 = wval;
                            end
                        end
                        `FLD_IDX_LV2_HYS: begin
                            if (wval <= `FLD_PCT_FULL) begin
                                s_d.hys2 = wval;
                            end
                        end
                        `FLD_IDX_BAND: begin
                            if (wval <= `FLD_PCT_FULL) begin
                                s_d.band = wval;
                            end
                        end
                        `FLD_IDX_IRQ_STS: begin
                            s_d.sts = s_q.sts & ~hwdata[2:0];
                        end
                        `FLD_IDX_IRQ_MSK: begin
                            s_d.msk = hwdata[2:0];
                        end
                        default: begin
                        end
                    endcase
                end
            end
            FLD_BUS_RDWAIT: begin
                // One wait state so a read always sees the last write
                s_d.rdata = 32'h0000_0000;
                if (s_q.hit) begin
                    case (s_q.idx)
                        `FLD_IDX_OUT1_SEL: begin
                            s_d.rdata[15:0] = s_q.sel[0];
                        end
                        `FLD_IDX_OUT2_SEL: begin
                            s_d.rdata[15:0] = s_q.sel[1];
                        end
                        `FLD_IDX_RLYA_SEL: begin
                            s_d.rdata[15:0] = s_q.sel[2];
                        end
                        `FLD_IDX_RLYB_SEL: begin
                            s_d.rdata[15:0] = s_q.sel[3];
                        end
                        `FLD_IDX_LV1_THR: begin
                            s_d.rdata[15:0] = s_q.thr1;
                        end
                        `FLD_IDX_LV1_HYS: begin
                            s_d.rdata[15:0] = s_q.hys1;
                        end
                        `FLD_IDX_LV2_THR: begin
                            s_d.rdata[15:0] = s_q.thr2;
                        end
                        `FLD_IDX_LV2_HYS: begin
                            s_d.rdata[15:0] = s_q.hys2;
                        end
                        `FLD_IDX_BAND: begin
                            s_d.rdata[15:0] = s_q.band;
                        end
                        `FLD_IDX_LIVE: begin
                            s_d.rdata[2:0] = {s_q.arr, s_q.det2, s_q.det1};
                        end
                        `FLD_IDX_IRQ_STS: begin
                            s_d.rdata[2:0] = s_q.sts;
                        end
                        `FLD_IDX_IRQ_MSK: begin
                            s_d.rdata[2:0] = s_q.msk;
                        end
                        default: begin
                        end
                    endcase
                end
                s_d.bus = FLD_BUS_RDDONE;
            end
            default: begin
            end
        endcase

        // Address phase; hready is low only during our own read wait
        if (hready) begin
            if (hsel && htrans[1]) begin
                s_d.idx = haddr[13:2];
                s_d.hit = (haddr[31:14] == 18'h0_0000) && (haddr[1:0] == 2'b00);
                s_d.bus = hwrite ? FLD_BUS_WRITE : FLD_BUS_RDWAIT;
            end else begin
                s_d.bus = FLD_BUS_IDLE;
            end
        end

        // Detectors act only on a fresh frequency sample
        if (run_in.update) begin
            if (run_in.freq > s_q.thr1) begin
                s_d.det1 = 1'b1;
            end else if (run_in.freq < s_q.thr1 - lag1) begin
                s_d.det1 = 1'b0;
            end else begin
                s_d.det1 = s_q.det1;
            end
            if (run_in.freq > s_q.thr2) begin
                s_d.det2 = 1'b1;
            end else if (run_in.freq < s_q.thr2 - lag2) begin
                s_d.det2 = 1'b0;
            end else begin
                s_d.det2 = s_q.det2;
            end
            s_d.arr = (band_lo >= {1'b0, ref_in.set_freq})
                   && ({1'b0, run_in.freq} <= band_hi);
        end

        // Any change of a detector is an event; set beats clear
        events = {s_d.arr ^ s_q.arr, s_d.det2 ^ s_q.det2, s_d.det1 ^ s_q.det1};
        s_d.sts = s_d.sts | events;
        s_d.irq = |(s_d.sts & s_d.msk);

        // Terminals follow the registered detector state
        s_d.term.output_terminal_one = route(s_q.sel[0], s_q.det1, s_q.det2, s_q.arr);
        s_d.term.output_terminal_two = route(s_q.sel[1], s_q.det1, s_q.det2, s_q.arr);
        s_d.term.relay_a_output      = route(s_q.sel[2], s_q.det1, s_q.det2, s_q.arr);
        s_d.term.relay_b_output      = route(s_q.sel[3], s_q.det1, s_q.det2, s_q.arr);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= ST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign hreadyout = (s_q.bus != FLD_BUS_RDWAIT);
    assign hresp     = 1'b0;
    assign hrdata    = s_q.rdata;
    assign term_out  = s_q.term;
    assign irq       = s_q.irq;

endmodule // fldet

// ===== fldet_assertions.sv
// Bus timing and terminal checks for the frequency level detector
`timescale 1ns/10ps
module fldet_assertions (
    // Clock and reset
    input wire logic                   hclk,
    input wire logic                   hresetn,
    // Register bus
    input wire logic                   hsel,
    input wire logic [31:0]            haddr,
    input wire logic [1:0]             htrans,
    input wire logic                   hwrite,
    input wire logic                   hready,
    input wire logic                   hreadyout,
    input wire logic                   hresp,
    input wire logic [31:0]            hrdata,
    // Frequency and terminals
    input wire fldet_pkg::fldet_freq_s run_in,
    input wire fldet_pkg::fldet_term_s term_out,
    input wire logic                   irq
);
    import fldet_pkg::*;
    logic       take;
    logic       rd_take;
    logic [2:0] quiet_q;
    assign take    = hready & hsel & htrans[1];
    assign rd_take = take & ~hwrite;
    // Cycles since anything could move a terminal or the interrupt
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quiet_q <= 3'h0;
        end else if (run_in.update || take) begin
            quiet_q <= 3'h0;
        end else if (quiet_q != 3'h7) begin
            quiet_q <= quiet_q + 3'h1;
        end
    end
    hresp_okay_a: assert property (@(posedge hclk) disable iff (!hresetn) hresp == 1'b0)
        else $error("hresp not OKAY");
    write_nowait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        take && hwrite |=> hreadyout) else $error("write stalled");
    read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_take |=> !hreadyout ##1 hreadyout) else $error("read wait not one cycle");
    wait_once_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !hreadyout |=> hreadyout) else $error("hreadyout low too long");
    rdata_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(hrdata) |-> $past(rd_take, 2)) else $error("hrdata moved without read");
    unmapped_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_take && haddr[31:14] != 18'h0 |-> ##2 hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    reset_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> term_out == 4'h0 && !irq) else $error("outputs not cleared");
    quiet_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        quiet_q >= 3'h5 |-> $stable(term_out) && $stable(irq))
        else $error("terminal moved without sample");
endmodule // fldet_assertions

bind fldet fldet_assertions u_fldet_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .run_in(run_in),
    .term_out(term_out), .irq(irq));

// ===== fldet_load.sv
// Relay and lamp loads wired to the output terminals
`timescale 1ns/10ps
module fldet_load (
    // Clock and reset
    input wire logic                   hclk,
    input wire logic                   hresetn,
    // Terminals from the drive
    input wire fldet_pkg::fldet_term_s term,
    // Energised loads
    output logic [3:0]                 load_on
);
    import fldet_pkg::*;
    // Contacts pick up a cycle late
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            load_on <= 4'h0;
        end else begin
            load_on <= term;
        end
    end
endmodule // fldet_load

// ===== freq_level_detect_bench.sv
// Register and detector tests for the frequency level detector
`timescale 1ns/10ps
`include "fldet_map.svh"
module freq_level_detect_bench;
    import fldet_pkg::*;
    logic        hclk = 0;
    logic        hresetn = 0;
    logic        hwrite = 0;
    logic [1:0]  htrans = 0;
    logic [31:0] haddr = 0;
    logic [31:0] hwdata = 0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    fldet_freq_s run_in = '0;
    fldet_ref_s  ref_in = {16'h1388, 16'h2710};
    fldet_term_s term;
    logic [3:0]  load_on;
    int          n_fail = 0;
    int          n_tests = 0;
    int          cyc = 0;
    logic [15:0] fq [11] = '{16'h07d0, 16'h07d1, 16'h0708, 16'h0707, 16'h076c, 16'h0bb9,
                             16'h05dc, 16'h05db, 16'h0fa0, 16'h1770, 16'h1771};
    logic [2:0]  ex [11] = '{3'h0, 3'h4, 3'h4, 3'h0, 3'h0, 3'h6, 3'h2, 3'h0, 3'h7, 3'h7, 3'h6};
    always #5 hclk = ~hclk;
    fldet dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .run_in(run_in),
        .ref_in(ref_in), .term_out(term), .irq(irq));
    fldet_load u_load (.hclk(hclk), .hresetn(hresetn), .term(term), .load_on(load_on));
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Waits are open ended; only the cycle ceiling ends a hang
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(negedge hclk); while (hreadyout !== 1'h1);
        @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(negedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
        @(posedge hclk);
    endtask
    task automatic wr(input logic [11:0] i, input logic [31:0] d);
        bus(1'h1, {18'h0, i, 2'h0}, d);
    endtask
    task automatic rdc(input logic [11:0] i, input logic [31:0] exp);
        bus(1'h0, {18'h0, i, 2'h0}, 32'h0);
        chk(rd, exp);
    endtask
    task automatic smp(input logic [15:0] f);
        @(posedge hclk);
        run_in <= '{freq: f, update: 1'h1};
        @(posedge hclk);
        run_in.update <= 1'h0;
        repeat (3) @(posedge hclk);
        @(negedge hclk);
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            end_of_test();
        end
    end
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'h1;
        @(negedge hclk);
        chk({28'h0, term}, 32'h0);
        rdc(`FLD_IDX_OUT1_SEL, 32'h2);
        rdc(`FLD_IDX_OUT2_SEL, 32'h2);
        rdc(`FLD_IDX_RLYA_SEL, 32'h8);
        rdc(`FLD_IDX_RLYB_SEL, 32'h0);
        rdc(`FLD_IDX_LV1_THR, 32'h01f4);
        rdc(`FLD_IDX_LV2_HYS, 32'h0);
        rdc(`FLD_IDX_BAND, 32'h0);
        $display("reset values done");
        wr(`FLD_IDX_OUT1_SEL, 32'h000f);
        wr(`FLD_IDX_OUT2_SEL, 32'h0010);
        wr(`FLD_IDX_RLYA_SEL, 32'h0011);
        wr(`FLD_IDX_RLYB_SEL, 32'h0003);
        wr(`FLD_IDX_LV1_THR, 32'h07d0);
        wr(`FLD_IDX_LV1_HYS, 32'h0064);
        wr(`FLD_IDX_LV2_THR, 32'h0bb8);
        wr(`FLD_IDX_LV2_HYS, 32'h01f4);
        wr(`FLD_IDX_BAND, 32'h0064);
        wr(`FLD_IDX_IRQ_MSK, 32'h7);
        wr(`FLD_IDX_LV1_THR, 32'h2711);
        rdc(`FLD_IDX_LV1_THR, 32'h07d0);
        wr(`FLD_IDX_LV1_HYS, 32'h03e9);
        rdc(`FLD_IDX_LV1_HYS, 32'h0064);
        wr(`FLD_IDX_LV2_THR, 32'h2711);
        rdc(`FLD_IDX_LV2_THR, 32'h0bb8);
        wr(`FLD_IDX_OUT1_SEL, 32'h0024);
        rdc(`FLD_IDX_OUT1_SEL, 32'h000f);
        bus(1'h0, 32'h0001_0000, 32'h0);
        chk(rd, 32'h0);
        $display("register access done");
        for (int k = 0; k < 11; k++) begin
            smp(fq[k]);
            chk({28'h0, term}, {28'h0, ex[k], 1'h0});
            chk({28'h0, load_on}, {28'h0, ex[k], 1'h0});
        end
        rdc(`FLD_IDX_LIVE, 32'h3);
        $display("detectors done");
        chk({31'h0, irq}, 32'h1);
        wr(`FLD_IDX_IRQ_STS, 32'h7);
        repeat (2) @(negedge hclk);
        chk({31'h0, irq}, 32'h0);
        wr(`FLD_IDX_IRQ_MSK, 32'h0);
        smp(16'h03e8);
        chk({31'h0, irq}, 32'h0);
        rdc(`FLD_IDX_IRQ_STS, 32'h3);
        wr(`FLD_IDX_IRQ_MSK, 32'h2);
        repeat (2) @(negedge hclk);
        chk({31'h0, irq}, 32'h1);
        wr(`FLD_IDX_LV1_THR, 32'h2710);
        rdc(`FLD_IDX_LV1_THR, 32'h2710);
        $display("interrupt done");
        // Terminals valid before a reset in mid-run, so the clear is seen
        smp(16'h0fa0);
        chk({28'h0, term}, 32'h6);
        @(posedge hclk);
        hresetn <= 1'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        @(negedge hclk);
        chk({31'h0, irq}, 32'h0);
        chk({28'h0, term}, 32'h0);
        chk({28'h0, load_on}, 32'h0);
        rdc(`FLD_IDX_IRQ_MSK, 32'h0);
        rdc(`FLD_IDX_LV1_THR, 32'h01f4);
        rdc(`FLD_IDX_LIVE, 32'h0);
        $display("second reset done");
        end_of_test();
    end
endmodule // freq_level_detect_bench
